/* core/ecp_ext_ctrl_top.sv */
// external control port: command pins, status pins, sequencer and wishbone registers
//
// Contract
// - power-state pin low off, high on
// - output-state pin follows output enable
// - busy pin high while firmware busy
// - limiter pin high when any limiter active
// - two sync outputs track running sequence
// - output-off falling edge disables output
// - output-on falling edge enables output
// - start falling edge begins sequence
// - stop falling edge ends sequence
// - hold falling edge pauses current step
// - branch inputs jump independently to targets
// - status pins always driven, any mode
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "ecp_consts.svh"
module ecp_ext_ctrl_top
    import ecp_pkg::*;
#(
    parameter int TICK_DIV = `ECP_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ECP_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // active-low command pins from the outside controller
    input wire logic out_off_n,
    input wire logic out_on_n,
    input wire logic seq_start_n,
    input wire logic seq_stop_n,
    input wire logic seq_hold_n,
    input wire logic seq_branch1_n,
    input wire logic seq_branch2_n,
    // instrument-side state
    input wire logic source_power_on,
    input wire logic fw_busy,
    input wire logic lim_peak_pos,
    input wire logic lim_peak_neg,
    input wire logic lim_avg,
    input wire logic lim_power,
    // status pins to the outside controller
    output logic stat_power_on,
    output logic stat_output_on,
    output logic stat_limiter,
    output logic stat_fw_busy,
    output logic seq_sync0,
    output logic seq_sync1,
    // output enable towards the power stage, and interrupt
    output logic power_out_en,
    output logic irq
);

    logic [`ECP_CMD_N-1:0] pin_fall;
    logic [`ECP_CMD_N-1:0] sw_cmd;
    logic [`ECP_CMD_N-1:0] cmd;
    logic tick;
    logic ext_en_r;
    logic [31:0] seq_cfg_r;
    logic [`ECP_STEP_LEN_W-1:0] step_len_r;
    logic [`ECP_IRQ_N-1:0] irq_stat_r;
    logic [`ECP_IRQ_N-1:0] irq_mask_r;
    logic [`ECP_IRQ_N-1:0] irq_ev;
    logic out_en_r;
    ecp_seq_state_t seq_state_r;
    ecp_seq_state_t seq_state_nxt;
    logic [`ECP_STEP_W-1:0] step_r;
    logic [`ECP_STEP_W-1:0] step_nxt;
    logic [`ECP_STEP_LEN_W-1:0] dwell_r;
    logic seq_done;
    logic step_adv;
    logic bus_req;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] rd_nxt;
    logic [`ECP_STEP_W-1:0] last_step;
    logic [`ECP_STEP_W-1:0] br1_step;
    logic [`ECP_STEP_W-1:0] br2_step;

    // command pins, msb first in command-bit order
    ecp_fall_detect #(
        .N(`ECP_CMD_N)
    ) u_fall (
        .clk(clk),
        .rst_n(rst_n),
        .cmd_n({seq_branch2_n, seq_branch1_n, seq_hold_n, seq_stop_n,
                seq_start_n, out_on_n, out_off_n}),
        .fall_pulse(pin_fall)
    );

    // step timing base
    ecp_tick_div #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // pin commands only count while the port is enabled; software commands always do
    assign cmd = (ext_en_r ? pin_fall : '0) | sw_cmd;

    assign last_step = seq_cfg_r[`ECP_CFG_LAST_LSB +: `ECP_STEP_W];
    assign br1_step = seq_cfg_r[`ECP_CFG_BR1_LSB +: `ECP_STEP_W];
    assign br2_step = seq_cfg_r[`ECP_CFG_BR2_LSB +: `ECP_STEP_W];

    // wishbone handshake: ack one cycle after the request, write lands on the ack edge
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_ack_o & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // read mux; unmapped addresses read zero and still get an ack
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `ECP_REG_CTRL: rd_nxt[`ECP_CTRL_EXT_EN] = ext_en_r;
            `ECP_REG_STATUS: begin
                rd_nxt[`ECP_ST_POWER] = stat_power_on;
                rd_nxt[`ECP_ST_OUTPUT] = stat_output_on;
                rd_nxt[`ECP_ST_LIMITER] = stat_limiter;
                rd_nxt[`ECP_ST_BUSY] = stat_fw_busy;
                rd_nxt[`ECP_ST_SYNC0] = seq_sync0;
                rd_nxt[`ECP_ST_SYNC1] = seq_sync1;
                rd_nxt[`ECP_ST_STATE_LSB +: 3] = seq_state_r;
                rd_nxt[`ECP_ST_STEP_LSB +: `ECP_STEP_W] = step_r;
            end
            `ECP_REG_IRQ_STAT: rd_nxt[`ECP_IRQ_N-1:0] = irq_stat_r;
            `ECP_REG_IRQ_MASK: rd_nxt[`ECP_IRQ_N-1:0] = irq_mask_r;
            `ECP_REG_SEQ_CFG: rd_nxt[11:0] = seq_cfg_r[11:0];
            `ECP_REG_STEP_LEN: rd_nxt[`ECP_STEP_LEN_W-1:0] = step_len_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // read data is captured as ack rises and held while ack stands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_en_r <= 1'(`ECP_CTRL_RST);
            seq_cfg_r <= `ECP_SEQ_CFG_RST;
            step_len_r <= `ECP_STEP_LEN_RST;
            irq_mask_r <= '0;
        end else if (wr_fire) begin
            case (wb_adr_i)
                `ECP_REG_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ext_en_r <= wb_dat_i[`ECP_CTRL_EXT_EN];
                    end
                end
                `ECP_REG_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        irq_mask_r <= wb_dat_i[`ECP_IRQ_N-1:0];
                    end
                end
                `ECP_REG_SEQ_CFG: begin
                    seq_cfg_r <= ((seq_cfg_r & ~wmask) | (wb_dat_i & wmask)) & 32'h0000_0fff;
                end
                `ECP_REG_STEP_LEN: begin
                    step_len_r <= (step_len_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // software command strobes: write-one pulses, read back as zero
    always_comb begin
        sw_cmd = '0;
        if (wr_fire && wb_adr_i == `ECP_REG_CMD && wb_sel_i[0]) begin
            sw_cmd = wb_dat_i[`ECP_CMD_N-1:0];
        end
    end

    // power output enable; off beats on when both arrive together, for safety
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_en_r <= 1'b0;
        end else if (cmd[`ECP_CMD_OUT_OFF] || !source_power_on) begin
            out_en_r <= 1'b0;
        end else if (cmd[`ECP_CMD_OUT_ON]) begin
            out_en_r <= 1'b1;
        end
    end

    assign power_out_en = out_en_r;

    // step advance: dwell counts ticks while running
    assign step_adv = (seq_state_r == ECP_SEQ_RUN) && tick && (dwell_r >= step_len_r);
    assign seq_done = step_adv && (step_r == last_step);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dwell_r <= '0;
        end else if (seq_state_r != ECP_SEQ_RUN || step_nxt != step_r
                     || seq_state_nxt != seq_state_r) begin
            dwell_r <= '0;
        end else if (tick) begin
            dwell_r <= dwell_r + 1'b1;
        end
    end

    // sequencer: stop beats hold beats branch beats start; hold keeps the step
    always_comb begin
        seq_state_nxt = seq_state_r;
        step_nxt = step_r;
        case (seq_state_r)
            ECP_SEQ_IDLE: begin
                if (cmd[`ECP_CMD_SEQ_START]) begin
                    seq_state_nxt = ECP_SEQ_RUN;
                    step_nxt = '0;
                end
            end
            ECP_SEQ_RUN, ECP_SEQ_HOLD: begin
                if (cmd[`ECP_CMD_SEQ_STOP]) begin
                    seq_state_nxt = ECP_SEQ_IDLE;
                    step_nxt = '0;
                end else if (cmd[`ECP_CMD_SEQ_HOLD]) begin
                    seq_state_nxt = ECP_SEQ_HOLD;
                end else if (cmd[`ECP_CMD_BRANCH1]) begin
                    step_nxt = br1_step;
                end else if (cmd[`ECP_CMD_BRANCH2]) begin
                    step_nxt = br2_step;
                end else if (cmd[`ECP_CMD_SEQ_START] && seq_state_r == ECP_SEQ_HOLD) begin
                    seq_state_nxt = ECP_SEQ_RUN; // start resumes a held sequence
                end else if (seq_done) begin
                    seq_state_nxt = ECP_SEQ_IDLE;
                    step_nxt = '0;
                end else if (step_adv) begin
                    step_nxt = step_r + 1'b1;
                end
            end
            default: begin
                seq_state_nxt = ECP_SEQ_IDLE;
                step_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_state_r <= ECP_SEQ_IDLE;
            step_r <= '0;
        end else begin
            seq_state_r <= seq_state_nxt;
            step_r <= step_nxt;
        end
    end

    // sync0 marks an active sequence, sync1 toggles on each step change while active and clears when the sequencer goes idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_sync0 <= 1'b0;
            seq_sync1 <= 1'b0;
        end else begin
            seq_sync0 <= seq_state_nxt != ECP_SEQ_IDLE;
            if (seq_state_nxt == ECP_SEQ_IDLE) begin
                seq_sync1 <= 1'b0;
            end else if (step_nxt != step_r) begin
                seq_sync1 <= ~seq_sync1;
            end
        end
    end

    // status pins are registered and never gated by the port enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_power_on <= 1'b0;
            stat_output_on <= 1'b0;
            stat_limiter <= 1'b0;
            stat_fw_busy <= 1'b0;
        end else begin
            stat_power_on <= source_power_on;
            stat_output_on <= out_en_r;
            stat_limiter <= lim_peak_pos | lim_peak_neg | lim_avg | lim_power;
            stat_fw_busy <= fw_busy;
        end
    end

    // sticky irq status: an event in the clearing cycle survives the clear
    assign irq_ev = {seq_done, cmd};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else if (wr_fire && wb_adr_i == `ECP_REG_IRQ_STAT && wb_sel_i[0]) begin
            irq_stat_r <= (irq_stat_r & ~wb_dat_i[`ECP_IRQ_N-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    // level interrupt, held while any unmasked bit is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule : ecp_ext_ctrl_top

/* common/ecp_consts.svh */
// offsets, field positions, reset values and timing counts of the external control port
`ifndef ECP_CONSTS_SVH
`define ECP_CONSTS_SVH

// wishbone register byte addresses
`define ECP_ADR_W 8
`define ECP_REG_CTRL 8'h00
`define ECP_REG_CMD 8'h04
`define ECP_REG_STATUS 8'h08
`define ECP_REG_IRQ_STAT 8'h0c
`define ECP_REG_IRQ_MASK 8'h10
`define ECP_REG_SEQ_CFG 8'h14
`define ECP_REG_STEP_LEN 8'h18

// ctrl register fields
`define ECP_CTRL_EXT_EN 0
`define ECP_CTRL_RST 32'h0000_0001

// command bit positions, shared by the pins, the command register and the irq status
`define ECP_CMD_N 7
`define ECP_CMD_OUT_OFF 0
`define ECP_CMD_OUT_ON 1
`define ECP_CMD_SEQ_START 2
`define ECP_CMD_SEQ_STOP 3
`define ECP_CMD_SEQ_HOLD 4
`define ECP_CMD_BRANCH1 5
`define ECP_CMD_BRANCH2 6
`define ECP_IRQ_SEQ_DONE 7
`define ECP_IRQ_N 8

// status register fields
`define ECP_ST_POWER 0
`define ECP_ST_OUTPUT 1
`define ECP_ST_LIMITER 2
`define ECP_ST_BUSY 3
`define ECP_ST_SYNC0 4
`define ECP_ST_SYNC1 5
`define ECP_ST_STATE_LSB 8
`define ECP_ST_STEP_LSB 12

// sequence config fields and reset values
`define ECP_STEP_W 4
`define ECP_CFG_LAST_LSB 0
`define ECP_CFG_BR1_LSB 4
`define ECP_CFG_BR2_LSB 8
`define ECP_SEQ_CFG_RST 32'h0000_0a57
`define ECP_STEP_LEN_W 16
`define ECP_STEP_LEN_RST 16'h0064

// step tick timing: one tick every microsecond at a 250 MHz clock
`define ECP_CLK_PERIOD_PS 4000
`define ECP_TICK_NS 1000
`define ECP_TICK_CYCLES ((`ECP_TICK_NS * 1000) / `ECP_CLK_PERIOD_PS)

`endif

/* common/ecp_pkg.sv */
// types of the external control port
package ecp_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ECP_SEQ_IDLE = 3'b001,
        ECP_SEQ_RUN = 3'b010,
        ECP_SEQ_HOLD = 3'b100
    } ecp_seq_state_t;

endpackage : ecp_pkg

/* core/ecp_fall_detect.sv */
// two-flop synchroniser and falling-edge pulse generator, one lane per command input
`timescale 1ns/1ps
module ecp_fall_detect #(
    parameter int N = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] cmd_n,
    output logic [N-1:0] fall_pulse
);

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_lane
            logic meta_r;
            logic sync_r;
            logic prev_r;
            logic pulse_r;
            // each lane owns its flop; the port bit is only a wire to it
            assign fall_pulse[gi] = pulse_r;
            // reset to the idle-high level so releasing reset never fakes an edge
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    prev_r <= 1'b1;
                    pulse_r <= 1'b0;
                end else begin
                    meta_r <= cmd_n[gi];
                    sync_r <= meta_r; // first flop feeds only this one
                    prev_r <= sync_r;
                    pulse_r <= prev_r & ~sync_r; // one pulse per fall
                end
            end
        end
    endgenerate

endmodule : ecp_fall_detect

/* core/ecp_tick_div.sv */
// free-running divider that gives a one-cycle enable every DIV clocks
`timescale 1ns/1ps
module ecp_tick_div #(
    parameter int DIV = 250
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    // count up through the period, pulse on wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : ecp_tick_div

/* sim/ecp_ext_ctrl_assertions.sv */
// concurrent checks on the pins and bus of the external control port
`timescale 1ns/1ps
module ecp_ext_ctrl_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic out_off_n,
    input wire logic out_on_n,
    input wire logic source_power_on,
    input wire logic fw_busy,
    input wire logic lim_peak_pos,
    input wire logic lim_peak_neg,
    input wire logic lim_avg,
    input wire logic lim_power,
    input wire logic stat_power_on,
    input wire logic stat_output_on,
    input wire logic stat_limiter,
    input wire logic stat_fw_busy,
    input wire logic power_out_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // status copies lag one cycle; the first edge after reset still shows reset values
    power_copy_a:
        assert property ($past(rst_n) |-> stat_power_on == $past(source_power_on))
        else $error("power status pin wrong");
    output_copy_a:
        assert property ($past(rst_n) |-> stat_output_on == $past(power_out_en))
        else $error("output status pin wrong");
    busy_copy_a:
        assert property ($past(rst_n) |-> stat_fw_busy == $past(fw_busy))
        else $error("busy status pin wrong");
    limiter_or_a:
        assert property ($past(rst_n) |-> stat_limiter ==
            $past(lim_peak_pos | lim_peak_neg | lim_avg | lim_power))
        else $error("limiter status pin wrong");
    // pin commands act four cycles after the pin falls
    pin_off_a:
        assert property ($fell(out_off_n) |-> ##4 !power_out_en)
        else $error("output not disabled by off pin");
    pin_on_a:
        assert property ($fell(out_on_n) && out_off_n && source_power_on [*1] |->
            ##4 power_out_en)
        else $error("output not enabled by on pin");
    no_source_a:
        assert property ((!source_power_on) [*5] |-> !power_out_en)
        else $error("output enabled without source power");
    bus_ack_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
endmodule : ecp_ext_ctrl_assertions

bind ecp_ext_ctrl_top ecp_ext_ctrl_assertions i_ecp_ext_ctrl_assertions (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .out_off_n(out_off_n), .out_on_n(out_on_n), .source_power_on(source_power_on),
    .fw_busy(fw_busy), .lim_peak_pos(lim_peak_pos), .lim_peak_neg(lim_peak_neg),
    .lim_avg(lim_avg), .lim_power(lim_power), .stat_power_on(stat_power_on),
    .stat_output_on(stat_output_on), .stat_limiter(stat_limiter),
    .stat_fw_busy(stat_fw_busy), .power_out_en(power_out_en));

/* sim/ecp_ctl_model.sv */
// outside controller model: idles every command pin high, pulls one low per command
`timescale 1ns/1ps
module ecp_ctl_model (
    input wire logic clk,
    output logic [6:0] cmd_n
);
    initial cmd_n = 7'h7f;
    // low two cycles, then high long enough for the next fall to be seen
    task press(input int k);
        @(posedge clk);
        cmd_n[k] <= 1'b0;
        repeat (2) @(posedge clk);
        cmd_n[k] <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : press
endmodule : ecp_ctl_model

/* sim/ecp_ext_ctrl_top_test.sv */
// self-checking bench for the external control port
`timescale 1ns/1ps
`include "ecp_consts.svh"
module ecp_ext_ctrl_top_test;
    logic clk, rst_n, req, we, src, busy, lpp, lpn, lav, lpw, s1;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, dat_o;
    logic [6:0] cmd_n;
    logic ack, st_pwr, st_out, st_lim, st_busy, sync0, sync1, pwr_en, irq;
    int n_mismatch = 0;
    int compares = 0;
    ecp_ctl_model i_ecp_ctl_model (.clk(clk), .cmd_n(cmd_n));
    // short tick keeps sequence steps brief
    ecp_ext_ctrl_top #(.TICK_DIV(2)) i_ecp_ext_ctrl_top (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .out_off_n(cmd_n[0]), .out_on_n(cmd_n[1]), .seq_start_n(cmd_n[2]),
        .seq_stop_n(cmd_n[3]), .seq_hold_n(cmd_n[4]), .seq_branch1_n(cmd_n[5]),
        .seq_branch2_n(cmd_n[6]), .source_power_on(src), .fw_busy(busy),
        .lim_peak_pos(lpp), .lim_peak_neg(lpn), .lim_avg(lav), .lim_power(lpw),
        .stat_power_on(st_pwr), .stat_output_on(st_out), .stat_limiter(st_lim),
        .stat_fw_busy(st_busy), .seq_sync0(sync0), .seq_sync1(sync1),
        .power_out_en(pwr_en), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task cp(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : cp
    // one classic cycle; held until ack is sampled high
    task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        req <= 1'b0;
    endtask : wbx
    task wr(input logic [7:0] a, input logic [31:0] d);
        wbx(1'b1, a, d);
    endtask : wr
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rc
    // step and state fields of the status register
    task rs(input string nm, input logic [7:0] e);
        wbx(1'b0, `ECP_REG_STATUS, 32'h0);
        chk(nm, {24'h0, e}, {24'h0, rdat[15:8]});
    endtask : rs
    task p(input int k);
        i_ecp_ctl_model.press(k);
        repeat (4) @(posedge clk);
    endtask : p
    task end_sim;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        {req, we, src, busy, lpp, lpn, lav, lpw} = 8'h00;
        {adr, wdat} = 40'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rc("ctrl", `ECP_REG_CTRL, `ECP_CTRL_RST);
        rc("seq_cfg", `ECP_REG_SEQ_CFG, `ECP_SEQ_CFG_RST);
        rc("step_len", `ECP_REG_STEP_LEN, 32'h0000_0064);
        rc("irq_mask", `ECP_REG_IRQ_MASK, 32'h0);
        wr(8'h1c, 32'hffff_ffff);
        rc("unmapped", 8'h1c, 32'h0);
        $display("test registers done");
        cp("stat_power_on", 1'h0, st_pwr);
        for (int i = 0; i < 4; i++) begin
            {lpp, lpn, lav, lpw} <= 4'h8 >> i;
            repeat (3) @(posedge clk);
            cp("stat_limiter", 1'h1, st_lim);
        end
        {src, busy, lpp, lpn, lav, lpw} <= 6'h30;
        repeat (3) @(posedge clk);
        cp("stat_power_on", 1'h1, st_pwr);
        cp("stat_fw_busy", 1'h1, st_busy);
        cp("stat_limiter", 1'h0, st_lim);
        $display("test status pins done");
        p(1);
        cp("power_out_en", 1'h1, pwr_en);
        cp("stat_output_on", 1'h1, st_out);
        p(0);
        cp("power_out_en", 1'h0, pwr_en);
        cp("stat_output_on", 1'h0, st_out);
        wr(`ECP_REG_CMD, 32'h2);
        repeat (3) @(posedge clk);
        rc("status", `ECP_REG_STATUS, 32'h0000_010b);
        src <= 1'b0;
        repeat (8) @(posedge clk);
        p(1);
        cp("power_out_en", 1'h0, pwr_en);
        src <= 1'b1;
        $display("test output control done");
        wr(`ECP_REG_IRQ_STAT, 32'hff);
        wr(`ECP_REG_IRQ_MASK, 32'h2);
        p(0);
        cp("irq", 1'h0, irq);
        p(1);
        cp("irq", 1'h1, irq);
        rc("irq_stat", `ECP_REG_IRQ_STAT, 32'h3);
        wr(`ECP_REG_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clk);
        cp("irq", 1'h0, irq);
        rc("irq_stat", `ECP_REG_IRQ_STAT, 32'h1);
        $display("test interrupt done");
        // long steps so branch targets stay visible while read back
        wr(`ECP_REG_STEP_LEN, 32'hffff);
        wr(`ECP_REG_SEQ_CFG, 32'h93f);
        p(2);
        cp("seq_sync0", 1'h1, sync0);
        rs("run", 8'h02);
        p(4);
        rs("hold", 8'h04);
        p(2);
        rs("resume", 8'h02);
        s1 = sync1;
        p(5);
        rs("branch1", 8'h32);
        cp("seq_sync1", ~s1, sync1);
        p(6);
        rs("branch2", 8'h92);
        p(3);
        rs("stop", 8'h01);
        cp("seq_sync0", 1'h0, sync0);
        cp("seq_sync1", 1'h0, sync1);
        wr(`ECP_REG_STEP_LEN, 32'h0);
        wr(`ECP_REG_SEQ_CFG, 32'h0);
        wr(`ECP_REG_IRQ_STAT, 32'hff);
        p(2);
        while (sync0 !== 1'b0) @(posedge clk);
        rc("irq_stat", `ECP_REG_IRQ_STAT, 32'h84);
        $display("test sequence done");
        // pins ignored while disabled, status pins still follow
        wr(`ECP_REG_CTRL, 32'h0);
        busy <= 1'b0;
        p(2);
        cp("seq_sync0", 1'h0, sync0);
        cp("stat_fw_busy", 1'h0, st_busy);
        wr(`ECP_REG_CTRL, 32'h1);
        $display("test port disable done");
        end_sim();
    end
endmodule : ecp_ext_ctrl_top_test
